// [core/radio_host.sv]
// Host controller for a radio receiver: SPI master plus Avalon-MM slave.
// Assumes the receiver's not-empty and mode-settled flags arrive on pins.
`timescale 1ns/1ps
`default_nettype none

module radio_host
   import radio_host_pkg::*;
#(
   parameter int HALF_CYCLES = SCK_HALF_CYC,
   parameter int GAP_CYCLES  = NSS_GAP_CYC
) (
   // Clock and reset
   input  wire logic        CLK_I,
   input  wire logic        RST_N_I,
   // Avalon-MM slave
   input  wire logic [3:0]  AVS_ADDRESS_I,
   input  wire logic        AVS_READ_I,
   input  wire logic        AVS_WRITE_I,
   input  wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0]      AVS_READDATA_O,
   output logic             AVS_WAITREQUEST_O,
   // Receiver SPI pins
   output logic             SPI_SCK_O,
   output logic             SPI_MOSI_O,
   output logic             SPI_NSS_N_O,
   input  wire logic        SPI_MISO_I,
   // Receiver status pins
   input  wire logic        QUEUE_NONEMPTY_I,
   input  wire logic        MODE_SETTLED_I
);

   // Gap counter is eight bits wide
   if (GAP_CYCLES < 4 || GAP_CYCLES > 256) begin
      $error("GAP_CYCLES must lie between 4 and 256");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync_a;
   logic [2:0] sync_b;
   logic       miso_s;
   logic       nonempty_s;
   logic       settled_s;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else begin
         sync_a <= {SPI_MISO_I, QUEUE_NONEMPTY_I, MODE_SETTLED_I};
         sync_b <= sync_a;
      end
   end

   assign miso_s     = sync_b[2];
   assign nonempty_s = sync_b[1];
   assign settled_s  = sync_b[0];

   // ----------------------------------------------------------------
   // Frame sequencer state
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE, S_SETTLE, S_LEAD, S_ADDR, S_FETCH, S_DATA, S_TRAIL, S_GUARD
   } state_e;

   state_e     state;
   logic       cmd_wnr;
   logic [6:0] cmd_addr;
   logic [6:0] cur_addr;
   logic [7:0] remaining;
   logic       drain;
   logic [7:0] tx_data;
   logic       tx_full;
   logic [7:0] rx_data;
   logic       rx_valid;
   logic       refused;
   logic [7:0] gap_cnt;
   logic       eng_start;
   logic [7:0] eng_tx;
   logic       eng_done;
   logic [7:0] eng_rx;
   logic       rd_ack;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire [1:0] word_sel  = AVS_ADDRESS_I[3:2];
   wire       sel_cmd   = (word_sel == CMD_OFS[3:2]);
   wire       sel_tx    = (word_sel == TXDATA_OFS[3:2]);
   wire       sel_rx    = (word_sel == RXDATA_OFS[3:2]);
   wire       sel_stat  = (word_sel == STATUS_OFS[3:2]);
   wire       tx_stall  = AVS_WRITE_I && sel_tx && tx_full;
   wire       wr_take   = AVS_WRITE_I && !tx_stall;
   wire       rd_take   = AVS_READ_I && rd_ack;
   wire       busy      = (state != S_IDLE);
   wire [7:0] new_cnt   = AVS_WRITEDATA_I[CMD_CNT_LSB +: 8];
   wire       new_drain = AVS_WRITEDATA_I[CMD_DRAIN_POS];
   wire       cmd_go    = wr_take && sel_cmd && !busy && (new_cnt != CNT_RESET);
   wire       cmd_bad   = wr_take && sel_cmd && (busy || new_cnt == CNT_RESET);

   assign AVS_WAITREQUEST_O = tx_stall || (AVS_READ_I && !rd_ack);

   // ----------------------------------------------------------------
   // Frame decisions
   // ----------------------------------------------------------------
   wire       gap_done  = (gap_cnt == 8'(GAP_CYCLES - 1));
   wire       is_queue  = (cmd_addr == QUEUE_ADDR);
   wire       in_patt   = (cur_addr >= PATTERN_FIRST_ADR) &&
                          (cur_addr <= PATTERN_LAST_ADR);
   wire       entry_on  = ((tx_data & ENTRY_TRIG_MASK) != BYTE_ZERO);
   wire       exit_on   = ((tx_data & EXIT_TRIG_MASK) != BYTE_ZERO);
   wire       bad_patt  = in_patt && (tx_data == BYTE_ZERO);
   wire       bad_auto  = (cur_addr == AUTO_SEQ_ADDR) && (entry_on != exit_on);
   wire       tx_refuse = cmd_wnr && tx_full && (bad_patt || bad_auto);
   wire       fetch_wr  = cmd_wnr && tx_full && !tx_refuse;
   wire       fetch_rd  = !cmd_wnr && !rx_valid;
   wire       last_byte = (remaining == 8'h01) || drain;
   wire       drain_more = drain && (remaining != CNT_RESET) && nonempty_s;
   wire [7:0] addr_byte = {cmd_wnr, cmd_addr};

   assign eng_tx    = (state == S_LEAD) ? addr_byte :
                      (cmd_wnr ? tx_data : BYTE_ZERO);
   assign eng_start = ((state == S_LEAD) && gap_done) ||
                      ((state == S_FETCH) && (fetch_wr || fetch_rd));

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         gap_cnt <= 8'h00;
      end else if (state == S_LEAD || state == S_TRAIL ||
                   state == S_GUARD) begin
         gap_cnt <= gap_done ? 8'h00 : gap_cnt + 8'h01;
      end else begin
         gap_cnt <= 8'h00;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         state <= S_IDLE;
      end else begin
         case (state)
            S_IDLE: begin
               if (cmd_go && new_drain) begin
                  state <= S_GUARD;
               end else if (cmd_go) begin
                  state <= S_SETTLE;
               end
            end
            S_SETTLE: begin
               if (settled_s || !is_queue) begin
                  state <= S_LEAD;
               end
            end
            S_LEAD: begin
               if (gap_done) begin
                  state <= S_ADDR;
               end
            end
            S_ADDR: begin
               if (eng_done) begin
                  state <= S_FETCH;
               end
            end
            S_FETCH: begin
               if (tx_refuse) begin
                  state <= S_TRAIL;
               end else if (fetch_wr || fetch_rd) begin
                  state <= S_DATA;
               end
            end
            S_DATA: begin
               if (eng_done) begin
                  state <= last_byte ? S_TRAIL : S_FETCH;
               end
            end
            S_TRAIL: begin
               if (gap_done) begin
                  state <= S_GUARD;
               end
            end
            // next frame restarts with an address byte
            S_GUARD: begin
               if (gap_done) begin
                  state <= drain_more ? S_SETTLE : S_IDLE;
               end
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Command latches and address tracking
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         cmd_wnr   <= 1'b0;
         cmd_addr  <= 7'h00;
         cur_addr  <= 7'h00;
         remaining <= CNT_RESET;
         drain     <= 1'b0;
      end else if (cmd_go) begin
         // Drain forces one-byte queue reads per frame
         cmd_wnr   <= new_drain ? 1'b0 : AVS_WRITEDATA_I[CMD_WNR_POS];
         cmd_addr  <= new_drain ? QUEUE_ADDR :
                      AVS_WRITEDATA_I[CMD_ADDR_LSB +: 7];
         cur_addr  <= new_drain ? QUEUE_ADDR :
                      AVS_WRITEDATA_I[CMD_ADDR_LSB +: 7];
         remaining <= new_cnt;
         drain     <= new_drain;
      end else if (state == S_DATA && eng_done) begin
         remaining <= remaining - 8'h01;
         if (!is_queue) begin
            cur_addr <= cur_addr + 7'h01;
         end
      end else if (state == S_FETCH && tx_refuse) begin
         remaining <= CNT_RESET;
      end
   end

   // ----------------------------------------------------------------
   // Data slots and refusal flag; hardware set wins over clear
   // ----------------------------------------------------------------
   wire tx_consume = (state == S_FETCH) && tx_full && cmd_wnr;
   wire rx_store   = (state == S_DATA) && eng_done;
   wire clr_ref    = wr_take && sel_stat && AVS_WRITEDATA_I[ST_REFUSE_POS];
   wire set_ref    = cmd_bad || ((state == S_FETCH) && tx_refuse);

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         tx_data <= BYTE_ZERO;
         tx_full <= 1'b0;
      end else if (wr_take && sel_tx) begin
         tx_data <= AVS_WRITEDATA_I[7:0];
         tx_full <= 1'b1;
      end else if (tx_consume) begin
         tx_full <= 1'b0;
      end
   end

   // old register contents kept on writes
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rx_data  <= BYTE_ZERO;
         rx_valid <= 1'b0;
      end else if (rx_store) begin
         rx_data  <= eng_rx;
         rx_valid <= !cmd_wnr;
      end else if (rd_take && sel_rx) begin
         rx_valid <= 1'b0;
      end
   end

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         refused <= 1'b0;
      end else if (set_ref) begin
         refused <= 1'b1;
      end else if (clr_ref) begin
         refused <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Read data, one wait state
   // ----------------------------------------------------------------
   wire [31:0] stat_word = {26'h0, refused, settled_s, nonempty_s,
                            rx_valid, tx_full, busy};
   wire [31:0] cmd_word  = {15'h0, drain, remaining, cmd_wnr, cmd_addr};
   wire [31:0] rd_mux    = sel_cmd  ? cmd_word :
                           sel_rx   ? {24'h0, rx_data} :
                           sel_stat ? stat_word : 32'h0000_0000;

   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rd_ack         <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
      end else begin
         rd_ack <= AVS_READ_I && !rd_ack;
         if (AVS_READ_I && !rd_ack) begin
            AVS_READDATA_O <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Serial engine and select
   // ----------------------------------------------------------------
   // host is the only master, mode 0
   spi_byte_engine #(
      .HALF_CYCLES (HALF_CYCLES)
   ) u_engine (
      .clk_i   (CLK_I),
      .rst_n_i (RST_N_I),
      .start_i (eng_start),
      .tx_i    (eng_tx),
      .busy_o  (),
      .done_o  (eng_done),
      .rx_o    (eng_rx),
      .miso_i  (miso_s),
      .sck_o   (SPI_SCK_O),
      .mosi_o  (SPI_MOSI_O)
   );

   // select low for the whole frame
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         SPI_NSS_N_O <= 1'b1;
      end else begin
         SPI_NSS_N_O <= !(state == S_LEAD || state == S_ADDR ||
                          state == S_FETCH || state == S_DATA ||
                          (state == S_TRAIL && !gap_done));
      end
   end

endmodule

`default_nettype wire

// [core/radio_host_pkg.sv]
// Package for the radio receiver host controller.
// Assumes a 25 MHz system clock and a register-mapped receiver behind SPI.
package radio_host_pkg;

   // ----------------------------------------------------------------
   // Local register map (Avalon-MM, byte offsets, one word each)
   // ----------------------------------------------------------------
   localparam logic [3:0] CMD_OFS    = 4'h0;
   localparam logic [3:0] TXDATA_OFS = 4'h4;
   localparam logic [3:0] RXDATA_OFS = 4'h8;
   localparam logic [3:0] STATUS_OFS = 4'hC;

   // ----------------------------------------------------------------
   // Command word fields
   // ----------------------------------------------------------------
   localparam int CMD_WNR_POS   = 7;
   localparam int CMD_ADDR_LSB  = 0;
   localparam int CMD_CNT_LSB   = 8;
   localparam int CMD_DRAIN_POS = 16;

   // ----------------------------------------------------------------
   // Status word fields
   // ----------------------------------------------------------------
   localparam int ST_BUSY_POS    = 0;
   localparam int ST_TXFULL_POS  = 1;
   localparam int ST_RXVALID_POS = 2;
   localparam int ST_NONEMPT_POS = 3;
   localparam int ST_SETTLE_POS  = 4;
   localparam int ST_REFUSE_POS  = 5;

   // ----------------------------------------------------------------
   // Receiver register addresses and trigger masks the controller watches
   // ----------------------------------------------------------------
   localparam logic [6:0] QUEUE_ADDR        = 7'h00;
   localparam logic [6:0] PATTERN_FIRST_ADR = 7'h2F;
   localparam logic [6:0] PATTERN_LAST_ADR  = 7'h36;
   localparam logic [6:0] AUTO_SEQ_ADDR     = 7'h3B;
   localparam logic [7:0] ENTRY_TRIG_MASK   = 8'hE0;
   localparam logic [7:0] EXIT_TRIG_MASK    = 8'h1C;

   // ----------------------------------------------------------------
   // Reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO      = 8'h00;
   localparam logic [7:0] CNT_RESET      = 8'h00;
   localparam int         CLK_HZ         = 25_000_000;
   localparam int         SCK_HALF_CYC   = 4;
   localparam int         NSS_GAP_CYC    = 8;

endpackage

// [core/spi_byte_engine.sv]
// One-byte SPI shifter, clock polarity 0 and phase 0, MSB first.
// Assumes miso_i is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none

module spi_byte_engine #(
   parameter int HALF_CYCLES = 4
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Byte request
   input  wire logic       start_i,
   input  wire logic [7:0] tx_i,
   output logic            busy_o,
   output logic            done_o,
   output logic [7:0]      rx_o,
   // Serial pins
   input  wire logic       miso_i,
   output logic            sck_o,
   output logic            mosi_o
);

   // Synchronised MISO lags the pin by up to two cycles
   if (HALF_CYCLES < 4) begin
      $error("HALF_CYCLES must be at least 4");
   end

   localparam int CW = $clog2(HALF_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

   logic [CW-1:0] cnt;
   logic [2:0]    bitn;
   logic [7:0]    sh;
   logic          tick;

   assign tick   = busy_o && (cnt == LAST);
   assign mosi_o = sh[7];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt <= '0;
      end else if (!busy_o || tick) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // sample on rise, shift on fall
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         sck_o  <= 1'b0;
         bitn   <= 3'h0;
         sh     <= 8'h00;
         rx_o   <= 8'h00;
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            busy_o <= 1'b1;
            sck_o  <= 1'b0;
            bitn   <= 3'h7;
            sh     <= tx_i;
         end else if (tick && !sck_o) begin
            sck_o <= 1'b1;
            rx_o  <= {rx_o[6:0], miso_i};
         end else if (tick) begin
            sck_o <= 1'b0;
            if (bitn == 3'h0) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end else begin
               bitn <= bitn - 3'h1;
               sh   <= {sh[6:0], 1'b0};
            end
         end
      end
   end

endmodule

`default_nettype wire

// [tb/radio_host_chk.sv]
// Checker for the host controller pins and local bus.
// Assumes it is bound into radio_host, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module radio_host_chk #(
   parameter int HALF_CYCLES = 4,
   parameter int GAP_CYCLES  = 8
) (
   // Clock and reset
   input  wire logic       CLK_I,
   input  wire logic       RST_N_I,
   // Local bus
   input  wire logic [3:0] AVS_ADDRESS_I,
   input  wire logic       AVS_READ_I,
   input  wire logic       AVS_WRITE_I,
   input  wire logic       AVS_WAITREQUEST_O,
   // Link pins
   input  wire logic       SPI_SCK_O,
   input  wire logic       SPI_MOSI_O,
   input  wire logic       SPI_NSS_N_O
);
   // ------
   // Helper counters
   // ------
   int unsigned hi_cnt;
   int unsigned gap_cnt;
   logic [11:0] bit_cnt;
   logic        sck_q;
   always_ff @(posedge CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         hi_cnt  <= 0;
         gap_cnt <= 0;
         bit_cnt <= 12'h000;
         sck_q   <= 1'b0;
      end else begin
         hi_cnt  <= SPI_SCK_O ? hi_cnt + 1 : 0;
         gap_cnt <= SPI_NSS_N_O ? gap_cnt + 1 : 0;
         sck_q   <= SPI_SCK_O;
         if (SPI_NSS_N_O)
            bit_cnt <= 12'h000;
         else if (SPI_SCK_O && !sck_q)
            bit_cnt <= bit_cnt + 12'h001;
      end
   end
   // ------
   // Assertions
   // ------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RST_N_I);
   sck_idle_a: assert property (SPI_NSS_N_O |-> !SPI_SCK_O)
      else $error("clock moves while deselected");
   sck_half_a: assert property ($fell(SPI_SCK_O) |-> hi_cnt == HALF_CYCLES)
      else $error("clock high phase has wrong length");
   mosi_hold_a: assert property (SPI_SCK_O |-> $stable(SPI_MOSI_O))
      else $error("data out changed while clock high");
   sck_sel_a: assert property ($rose(SPI_SCK_O) |-> !SPI_NSS_N_O)
      else $error("clock rose outside a frame");
   sel_lead_a: assert property ($fell(SPI_NSS_N_O) |-> !SPI_SCK_O [*8])
      else $error("clock started too soon after select");
   byte_whole_a: assert property ($rose(SPI_NSS_N_O) |->
      bit_cnt != 12'h000 && bit_cnt[2:0] == 3'h0)
      else $error("frame ended inside a byte");
   sel_gap_a: assert property ($fell(SPI_NSS_N_O) |-> gap_cnt >= GAP_CYCLES)
      else $error("select high gap too short");
   rd_wait_a: assert property ($rose(AVS_READ_I) |->
      AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
      else $error("read answer not after one wait state");
   wr_fast_a: assert property (AVS_WRITE_I && AVS_ADDRESS_I[3:2] != 2'b01
      |-> !AVS_WAITREQUEST_O)
      else $error("write stalled outside data slot");
   frame_c: cover property ($rose(SPI_NSS_N_O));
   stall_c: cover property (AVS_WRITE_I && AVS_WAITREQUEST_O);
   read_c: cover property ($rose(AVS_READ_I));
endmodule
`default_nettype wire

// [tb/rx_model.sv]
// Receiver model: SPI slave, register file and receive queue.
// Assumes the host drives a clock idle low and changes data on falls.
`timescale 1ns/1ps
`default_nettype none
module rx_model (
   // Link pins
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic nss_n_i,
   output logic      miso_o,
   // Status pin
   output logic      nonempty_o
);
   logic [7:0] regs [0:127];
   logic [7:0] q [$];
   logic [7:0] sh, tx, abyte;
   logic [6:0] adr;
   logic       wr, first, qrd, drv, overrun;
   int         bitn, pops;
   logic       level;
   // Flag and threshold addresses of the model are arbitrary
   localparam logic [6:0] FLAG_ADR = 7'h28;
   localparam logic [6:0] THR_ADR  = 7'h3C;
   initial begin
      for (int i = 0; i < 128; i++)
         regs[i] = {1'b1, i[6:0]};
      {tx, sh, abyte, adr, wr, qrd, drv, overrun, level} = '0;
      first = 1'b1;
      bitn = 0;
      pops = 0;
      nonempty_o = 1'b0;
   end
   // queue of 66 bytes, overflow dropped
   task automatic load(input logic [7:0] b);
      if (q.size() < 66)
         q.push_back(b);
      else
         overrun = 1'b1;
      nonempty_o = 1'b1;
   endtask
   // frame restart, flag refreshed at select edges
   always @(nss_n_i) begin
      nonempty_o = (q.size() != 0);
      // level flag above threshold, low at or below
      level = q.size() > int'(regs[THR_ADR]);
      bitn = 0;
      first = 1'b1;
      qrd = 1'b0;
   end
   always @(posedge sck_i) begin
      if (!nss_n_i) begin
         sh = {sh[6:0], mosi_i};
         bitn = bitn + 1;
         if (bitn == 1 && qrd) begin
            void'(q.pop_front());
            pops++;
         end
         if (bitn == 8) begin
            bitn = 0;
            if (first) begin
               {wr, adr} = sh;
               abyte = sh;
               first = 1'b0;
            end else begin
               if (wr && adr != 7'h00)
                  regs[adr] = sh;
               // a 1 in the overrun bit clears flag and queue
               if (wr && adr == FLAG_ADR && sh[4]) begin
                  overrun = 1'b0;
                  q.delete();
               end
               if (adr != 7'h00)
                  adr = adr + 7'h01;
            end
            // Old contents loaded before any write lands
            qrd = !wr && adr == 7'h00;
            tx = qrd ? (q.size() != 0 ? q[0] : 8'h00) : regs[adr];
         end
      end
   end
   // drive on fall, inverted last bit while deselected
   always @(negedge sck_i) begin
      if (!nss_n_i) begin
         drv = tx[7];
         tx = {tx[6:0], ~tx[7]};
      end
   end
   assign miso_o = nss_n_i ? ~drv : drv;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// Bench for the host controller against the receiver model.
// Assumes default design parameters and a 25 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import radio_host_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat, junk, v;
   logic        wreq, sck, mosi, nss, miso, nonempty;
   logic        settled = 1'b1;
   int          error_cnt = 0;
   int          comparisons = 0;
   always #20 clk = ~clk;
   radio_host u_radio_host (.CLK_I(clk), .RST_N_I(rst_n),
      .AVS_ADDRESS_I(adr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
      .AVS_WRITEDATA_I(wdat), .AVS_READDATA_O(rdat),
      .AVS_WAITREQUEST_O(wreq), .SPI_SCK_O(sck), .SPI_MOSI_O(mosi),
      .SPI_NSS_N_O(nss), .SPI_MISO_I(miso),
      .QUEUE_NONEMPTY_I(nonempty), .MODE_SETTLED_I(settled));
   rx_model u_rx_model (.sck_i(sck), .mosi_i(mosi), .nss_n_i(nss),
      .miso_o(miso), .nonempty_o(nonempty));
   // ------
   // Shared tasks
   // ------
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic give_up(input string nm);
      error_cnt++;
      $display("mismatch %s expected answer seen timeout", nm);
      report_and_stop;
   endtask
   task automatic check(input string nm, input logic [31:0] e, s);
      comparisons++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Holds the request until waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clk);
      adr <= a;
      wdat <= d;
      rd <= !w;
      wr <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 3000);
      r = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 3000)
         give_up("waitrequest");
   endtask
   task automatic wait_bit(input int b, input logic val);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         bus(1'b0, STATUS_OFS, 32'h00000000, s);
         n++;
      end while (s[b] !== val && n < 400);
      if (n >= 400)
         give_up("status wait");
   endtask
   // Commands are refused while a frame or its guard gap runs
   task automatic send_cmd(input logic [31:0] c);
      wait_bit(ST_BUSY_POS, 1'b0);
      bus(1'b1, CMD_OFS, c, junk);
   endtask
   task automatic get_rx(input logic [31:0] e);
      logic [31:0] r;
      wait_bit(ST_RXVALID_POS, 1'b1);
      bus(1'b0, RXDATA_OFS, 32'h00000000, r);
      check("rxdata", e, r);
   endtask
   task automatic wr_frame(input logic [6:0] a, input logic [7:0] d,
                           output logic [31:0] st);
      send_cmd({16'h0001, 1'b1, a});
      bus(1'b1, TXDATA_OFS, {24'h000000, d}, junk);
      wait_bit(ST_BUSY_POS, 1'b0);
      bus(1'b0, STATUS_OFS, 32'h00000000, st);
      bus(1'b1, STATUS_OFS, 32'h00000020, junk);
   endtask
   // ------
   // Scenarios
   // ------
   task automatic sc_reset;
      // Status pins need two edges through their synchronisers
      repeat (2) @(posedge clk);
      bus(1'b0, STATUS_OFS, 32'h00000000, v);
      check("status", 32'h00000010, v);
      bus(1'b0, CMD_OFS, 32'h00000000, v);
      check("cmd", 32'h00000000, v);
      bus(1'b0, TXDATA_OFS, 32'h00000000, v);
      check("txdata", 32'h00000000, v);
   endtask
   task automatic sc_single;
      send_cmd(32'h00000105);
      get_rx(32'h00000085);
      check("addr byte", 32'h00000005, {24'h0, u_rx_model.abyte});
   endtask
   task automatic sc_burst;
      send_cmd(32'h00000390);
      for (int i = 1; i <= 3; i++)
         bus(1'b1, TXDATA_OFS, i * 32'h00000011, junk);
      wait_bit(ST_BUSY_POS, 1'b0);
      for (int i = 0; i < 3; i++)
         check("reg", (i + 1) * 32'h11, {24'h0, u_rx_model.regs[16 + i]});
      bus(1'b0, RXDATA_OFS, 32'h00000000, v);
      check("old value", 32'h00000092, v);
      send_cmd(32'h00000210);
      get_rx(32'h00000011);
      get_rx(32'h00000022);
   endtask
   task automatic sc_queue;
      for (int i = 0; i < 5; i++)
         u_rx_model.load(8'hC1 + i[7:0]);
      send_cmd(32'h00000200);
      get_rx(32'h000000C1);
      get_rx(32'h000000C2);
      send_cmd(32'h00010500);
      for (int i = 3; i < 6; i++)
         get_rx(32'h000000C0 + i);
      wait_bit(ST_BUSY_POS, 1'b0);
      check("queue reads", 32'h00000005, u_rx_model.pops);
   endtask
   task automatic sc_settle;
      settled <= 1'b0;
      u_rx_model.load(8'h5E);
      send_cmd(32'h00000100);
      repeat (40) @(posedge clk);
      check("select held", 32'h00000001, {31'h0, nss});
      settled <= 1'b1;
      get_rx(32'h0000005E);
   endtask
   task automatic sc_refuse;
      logic [7:0] b [3] = '{8'h20, 8'h04, 8'h24};
      wr_frame(7'h2F, 8'h00, v);
      check("refused", 32'h00000001, {31'h0, v[ST_REFUSE_POS]});
      check("pattern", 32'h000000AF, {24'h0, u_rx_model.regs[47]});
      for (int i = 0; i < 3; i++) begin
         wr_frame(AUTO_SEQ_ADDR, b[i], v);
         check("refused", {31'h0, i < 2}, {31'h0, v[ST_REFUSE_POS]});
         check("auto", i < 2 ? 32'hBB : 32'h24, {24'h0, u_rx_model.regs[59]});
      end
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      sc_reset;
      sc_single;
      sc_burst;
      sc_queue;
      sc_settle;
      sc_refuse;
      report_and_stop;
   end
endmodule
bind radio_host radio_host_chk #(.HALF_CYCLES(HALF_CYCLES),
   .GAP_CYCLES(GAP_CYCLES)) u_radio_host_chk (.CLK_I(CLK_I),
   .RST_N_I(RST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
   .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .SPI_SCK_O(SPI_SCK_O),
   .SPI_MOSI_O(SPI_MOSI_O), .SPI_NSS_N_O(SPI_NSS_N_O));
`default_nettype wire
